// ### hw/rst_seq_pkg.sv
// constants and carrier types for the reset and clock phase sequencer
package rst_seq_pkg;
   // input clock rate and the stretch of internal reset after pin release
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int STRETCH_CYCLES = 512;
   localparam int STRETCH_W = 10;
   localparam logic [STRETCH_W-1:0] STRETCH_LAST = 10'h1FF;
   // divider: slow ratio used during reset phases
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
   localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
   // register map, byte addresses on the avalon slave
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
   // control register fields and reset values
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_PLL_BIT = 1;
   localparam logic CTRL_SRC_RESET = 1'b0;
   localparam logic CTRL_PLL_RESET = 1'b0;
   // status register fields
   localparam int STAT_PHASE_LSB = 0;
   localparam int STAT_BOOT_LSB = 2;
   localparam int STAT_ENDIAN_BIT = 4;
   localparam int STAT_BYPASS_BIT = 5;
   localparam int STAT_IRST_BIT = 6;
   localparam logic [1:0] PHASE_CODE_PIN = 2'h0;
   localparam logic [1:0] PHASE_CODE_STRETCH = 2'h1;
   localparam logic [1:0] PHASE_CODE_RUN = 2'h2;

   typedef enum logic [1:0] {PH_PIN, PH_STRETCH, PH_RUN} phase_e;

   // one avalon-mm request as seen by the slave
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avs_req_s;
endpackage

// ### hw/reset_clock_phase_sequencer.sv
// reset phase sequencer with clock ratio control and avalon-mm registers
`timescale 1ns/1ps
module reset_clock_phase_sequencer
   import rst_seq_pkg::*;
#(
   parameter bit HIZ_VARIANT = 1'b0 // 0: clock outs driven low, 1: mem and second aux clock outs released, third aux still driven low
) (
   input wire logic i_clk, // input clock, 50 MHz
   input wire logic i_rst, // synchronous power-on reset, active high
   input wire logic i_reset_pin_n, // external reset pin, active low
   input wire logic i_input_clock_mode_bit, // 1: direct input clock in use
   input wire logic [1:0] i_boot_select, // boot strap bits
   input wire logic i_endian_select, // endianness strap
   input wire logic i_ext_mem_clock, // external memory clock, source select 1
   input wire rst_seq_pkg::avs_req_s i_avs, // avalon-mm request
   output logic [31:0] o_avs_readdata, // avalon read data
   output logic o_avs_waitrequest, // avalon wait, low for one answer cycle
   output logic o_internal_reset, // stretched internal reset, active high
   output logic o_groups_valid, // all signal groups valid
   output logic o_cpu_clk_en, // cpu clock enable pulse
   output logic o_periph_clk_en, // peripheral clock enable pulse
   output logic o_mem_if_clk_en, // memory interface clock enable pulse
   output logic o_mem_clock_out, // memory clock pin level
   output logic o_mem_clock_out_oe, // memory clock pin enable
   output logic o_aux_clock_out_a, // second aux clock pin level
   output logic o_aux_clock_out_a_oe, // second aux clock pin enable
   output logic o_aux_clock_out_a_valid, // second aux clock valid
   output logic o_aux_clock_out_b, // third aux clock pin level
   output logic o_aux_clock_out_b_oe, // third aux clock pin enable
   output logic o_mem_bus_oe, // memory bus and hold acknowledge enable
   output logic o_bus_request_valid, // bus request flag valid
   output logic o_serial_timer_oe, // serial port and timer pins enable
   output logic [1:0] o_boot_select, // latched boot selection
   output logic o_endian_select, // latched endianness
   output logic o_pll_bypass // pll bypassed
);
   import rst_seq_pkg::*;

   typedef struct packed {
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      phase_e phase;
      logic [STRETCH_W-1:0] stretch_cnt;
      logic [DIV_W-1:0] div_cnt;
      logic [1:0] boot;
      logic endian;
      logic ctrl_src;
      logic ctrl_pll;
      logic ack;
      logic [31:0] rdata;
      logic irst;
      logic valid;
      logic cpu_en;
      logic per_en;
      logic mem_en;
      logic mem_clk;
      logic mem_oe;
      logic aux_a;
      logic aux_a_oe;
      logic aux_a_valid;
      logic aux_b;
      logic aux_b_oe;
      logic bus_oe;
      logic bus_request_flag_valid;
      logic ser_oe;
      logic bypass;
   } state_s;

   state_s state;
   state_s next_state;

   // status code of a phase, used by the status read
   function automatic logic [1:0] phase_code(input phase_e ph);
      case (ph)
         PH_PIN: phase_code = PHASE_CODE_PIN;
         PH_STRETCH: phase_code = PHASE_CODE_STRETCH;
         PH_RUN: phase_code = PHASE_CODE_RUN;
         default: phase_code = PHASE_CODE_PIN;
      endcase
   endfunction

   logic pin_rise;
   logic req;
   logic slow_tick;
   logic run;

   // pin edge taken from the second sync stage only
   assign pin_rise = state.pin_s2 && !state.pin_prev;
   assign req = i_avs.read || i_avs.write;
   assign slow_tick = (state.div_cnt == DIV_LAST);
   assign run = (state.phase == PH_RUN);

   // next state of the whole block
   always_comb begin
      next_state = state;
      // two-flop synchroniser on the reset pin
      next_state.pin_s1 = i_reset_pin_n;
      next_state.pin_s2 = state.pin_s1;
      next_state.pin_prev = state.pin_s2;
      next_state.div_cnt = state.div_cnt + 3'h1;

      // phase sequence: pin low wins over everything else
      case (state.phase)
         PH_PIN: begin
            if (pin_rise) begin
               next_state.phase = PH_STRETCH;
               next_state.stretch_cnt = '0;
               // restart the divider so 512 ends on a divide-by-8 boundary
               next_state.div_cnt = DIV_RESET;
               // straps caught on the release edge; hold time covers sync lag
               next_state.boot = i_boot_select;
               next_state.endian = i_endian_select;
            end
         end
         PH_STRETCH: begin
            next_state.stretch_cnt = state.stretch_cnt + 10'h001;
            if (state.stretch_cnt == STRETCH_LAST && slow_tick) begin
               next_state.phase = PH_RUN;
            end
         end
         PH_RUN: begin
         end
         default: next_state.phase = PH_PIN;
      endcase
      if (!state.pin_s2) begin
         next_state.phase = PH_PIN;
         next_state.stretch_cnt = '0;
      end

      // clock enables: slow ratio until the run phase
      next_state.cpu_en = run ? 1'b1 : slow_tick;
      next_state.per_en = run ? state.div_cnt[0] : slow_tick;
      next_state.mem_en = run ? state.div_cnt[0] : slow_tick;

      // output clock levels, driven once the pin is released
      if (!state.pin_s2) begin
         next_state.mem_clk = 1'b0;
         next_state.mem_oe = !HIZ_VARIANT;
         next_state.aux_a = 1'b0;
         next_state.aux_a_oe = !HIZ_VARIANT;
         next_state.aux_a_valid = 1'b0;
         next_state.aux_b = 1'b0;
         next_state.aux_b_oe = 1'b1;
      end else begin
         if (state.ctrl_src) begin
            next_state.mem_clk = i_ext_mem_clock;
         end else begin
            next_state.mem_clk = run ? state.div_cnt[0] : state.div_cnt[2];
         end
         next_state.mem_oe = 1'b1;
         next_state.aux_a = run ? state.div_cnt[0] : state.div_cnt[2];
         next_state.aux_a_oe = 1'b1;
         next_state.aux_a_valid = 1'b1;
         next_state.aux_b = state.div_cnt[2];
         next_state.aux_b_oe = 1'b1;
      end

      // pin groups come back only when the stretched reset is over
      next_state.irst = (next_state.phase != PH_RUN);
      next_state.valid = (next_state.phase == PH_RUN);
      next_state.bus_oe = next_state.valid && state.pin_s2;
      next_state.bus_request_flag_valid = next_state.valid && state.pin_s2;
      next_state.ser_oe = next_state.valid && state.pin_s2;

      // avalon slave: one wait cycle, answer while waitrequest is low
      next_state.ack = req && !state.ack;
      if (req && !state.ack) begin
         next_state.rdata = '0;
         if (i_avs.read && i_avs.address == CTRL_OFFSET) begin
            next_state.rdata[CTRL_SRC_BIT] = state.ctrl_src;
            next_state.rdata[CTRL_PLL_BIT] = state.ctrl_pll;
         end else if (i_avs.read && i_avs.address == STATUS_OFFSET) begin
            next_state.rdata[STAT_PHASE_LSB +: 2] = phase_code(state.phase);
            next_state.rdata[STAT_BOOT_LSB +: 2] = state.boot;
            next_state.rdata[STAT_ENDIAN_BIT] = state.endian;
            next_state.rdata[STAT_BYPASS_BIT] = state.bypass;
            next_state.rdata[STAT_IRST_BIT] = state.irst;
         end
      end
      // writes land on the edge where the master sees waitrequest low
      if (i_avs.write && state.ack && i_avs.address == CTRL_OFFSET && i_avs.byteenable[0]) begin
         next_state.ctrl_src = i_avs.writedata[CTRL_SRC_BIT];
         next_state.ctrl_pll = i_avs.writedata[CTRL_PLL_BIT];
      end
      // any reset phase drops the pll request, so the block wakes bypassed
      if (!run) begin
         next_state.ctrl_pll = CTRL_PLL_RESET;
      end
      next_state.bypass = !(run && next_state.ctrl_pll);
   end

   // single register bank; all outputs come from it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= '0;
         state.phase <= PH_PIN;
         state.irst <= 1'b1;
         state.bypass <= 1'b1;
         state.ctrl_src <= CTRL_SRC_RESET;
         state.ctrl_pll <= CTRL_PLL_RESET;
         state.aux_b_oe <= 1'b1;
         state.mem_oe <= !HIZ_VARIANT;
         state.aux_a_oe <= !HIZ_VARIANT;
      end else begin
         state <= next_state;
      end
   end

   assign o_avs_readdata = state.rdata;
   assign o_avs_waitrequest = !state.ack;
   assign o_internal_reset = state.irst;
   assign o_groups_valid = state.valid;
   assign o_cpu_clk_en = state.cpu_en;
   assign o_periph_clk_en = state.per_en;
   assign o_mem_if_clk_en = state.mem_en;
   assign o_mem_clock_out = state.mem_clk;
   assign o_mem_clock_out_oe = state.mem_oe;
   assign o_aux_clock_out_a = state.aux_a;
   assign o_aux_clock_out_a_oe = state.aux_a_oe;
   assign o_aux_clock_out_a_valid = state.aux_a_valid;
   assign o_aux_clock_out_b = state.aux_b;
   assign o_aux_clock_out_b_oe = state.aux_b_oe;
   assign o_mem_bus_oe = state.bus_oe;
   assign o_bus_request_valid = state.bus_request_flag_valid;
   assign o_serial_timer_oe = state.ser_oe;
   assign o_boot_select = state.boot;
   assign o_endian_select = state.endian;
   assign o_pll_bypass = state.bypass;

   // checks on the sequence, all in the input clock domain
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   stretch_length_a: assert property (
      (run && $past(state.phase) == PH_STRETCH) |-> $past(state.stretch_cnt) == STRETCH_LAST)
      else $error("internal reset not stretched by 512 cycles");

   groups_valid_a: assert property (
      o_groups_valid |-> (run && !o_internal_reset))
      else $error("groups valid before internal reset ended");

   boot_latch_a: assert property (
      (state.phase == PH_PIN && pin_rise) |=> (o_boot_select == $past(i_boot_select)
         && o_endian_select == $past(i_endian_select)))
      else $error("straps not captured at release");

   pll_bypass_a: assert property (
      (state.phase != PH_RUN) |=> o_pll_bypass)
      else $error("pll not bypassed during reset");

   cpu_slow_a: assert property (
      (!run && !slow_tick) |=> !o_cpu_clk_en)
      else $error("cpu enable too fast in reset");

   cpu_full_a: assert property (
      (run && $past(run) && state.pin_s2) |=> o_cpu_clk_en [*2])
      else $error("cpu clock not undivided after reset");

   periph_half_a: assert property (
      (run && $past(run) && state.pin_s2 && o_periph_clk_en)
         |=> !o_periph_clk_en ##1 o_periph_clk_en)
      else $error("peripheral clock not divide by two");

   mem_source_a: assert property (
      ($past(run) && !$past(state.ctrl_src) && state.pin_prev)
         |-> o_mem_clock_out == $past(state.div_cnt[0]))
      else $error("mem clock out not following mem if clock");

   aux_b_slow_a: assert property (
      $past(state.pin_s2) |-> o_aux_clock_out_b == $past(state.div_cnt[2]))
      else $error("third aux clock not divide by eight");

   pins_released_a: assert property (
      !state.pin_s2 |=> (!o_mem_bus_oe && !o_serial_timer_oe && !o_bus_request_valid))
      else $error("pin groups driven while reset pin low");

   aux_reset_level_a: assert property (
      !state.pin_s2 |=> (!o_aux_clock_out_b && o_aux_clock_out_b_oe
         && o_mem_clock_out_oe == !HIZ_VARIANT && !o_aux_clock_out_a_valid))
      else $error("clock outputs wrong while reset pin low");

   clocks_valid_a: assert property (
      $rose(state.pin_s2) |-> ##[1:3] (o_mem_clock_out_oe && o_aux_clock_out_a_valid
         && o_aux_clock_out_b_oe))
      else $error("output clocks late after release");

   ratio_boundary_a: assert property (
      $rose(run) |-> $past(state.div_cnt) == DIV_LAST)
      else $error("ratio switched off a slow clock boundary");

   // pin groups, slow phases and the register answer
   stretch_slow_a: assert property (
      (state.phase == PH_STRETCH && !slow_tick) |=> !o_cpu_clk_en)
      else $error("cpu enable too fast in stretch");

   slow_enables_a: assert property (
      (!run && !slow_tick) |=> (!o_periph_clk_en && !o_mem_if_clk_en))
      else $error("peripheral enables too fast in reset");

   mem_if_half_a: assert property (
      (run && $past(run) && state.pin_s2 && o_mem_if_clk_en)
         |=> !o_mem_if_clk_en ##1 o_mem_if_clk_en)
      else $error("memory interface clock not divide by two");

   stretch_hold_a: assert property (
      (state.phase == PH_STRETCH && state.pin_s2 && state.stretch_cnt != STRETCH_LAST)
         |=> state.phase == PH_STRETCH)
      else $error("internal reset ended early");

   irst_phase_a: assert property (
      o_internal_reset == (state.phase != PH_RUN))
      else $error("internal reset disagrees with phase");

   bus_request_flag_invalid_a: assert property (
      o_internal_reset |-> !o_bus_request_valid)
      else $error("bus request valid during reset");

   groups_hiz_a: assert property (
      o_internal_reset |-> (!o_serial_timer_oe && !o_mem_bus_oe))
      else $error("serial or memory pins driven during reset");

   mem_clk_low_a: assert property (
      !state.pin_s2 |=> (!o_mem_clock_out
         && o_mem_clock_out_oe == !HIZ_VARIANT))
      else $error("mem clock out wrong while reset pin low");

   aux_a_reset_a: assert property (
      !state.pin_s2 |=> (!o_aux_clock_out_a
         && o_aux_clock_out_a_oe == !HIZ_VARIANT))
      else $error("second aux clock wrong while reset pin low");

   strap_stable_a: assert property (
      !(state.phase == PH_PIN && pin_rise)
         |=> ($stable(o_boot_select) && $stable(o_endian_select)))
      else $error("straps changed outside release");

   avs_answer_a: assert property (
      ((i_avs.read || i_avs.write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
      else $error("avalon request not answered after one wait");

   avs_single_a: assert property (
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("avalon answer held longer than one cycle");

   stretch_seen_c: cover property (state.phase == PH_STRETCH ##1 run);
   reset_mid_stretch_c: cover property (state.phase == PH_STRETCH ##1 state.phase == PH_PIN);
   ctrl_write_c: cover property (i_avs.write && state.ack);
   ext_source_c: cover property (run && state.ctrl_src);
   aux_a_run_c: cover property (run && o_aux_clock_out_a);
endmodule

// ### verif/board_reset_src.sv
// board reset source and boot strap resistors facing the sequencer
`timescale 1ns/1ps
module board_reset_src #(
   parameter int STRAP_HOLD = 4 // cycles the straps stay after pin rise
) (
   input wire logic i_clk, // input clock
   input wire logic i_hold_low, // bench command: hold the reset pin low
   input wire logic [1:0] i_boot, // boot strap value to present
   input wire logic i_endian, // endian strap value to present
   output logic o_reset_pin_n, // reset pin, active low
   output logic [1:0] o_boot_select, // boot strap lines
   output logic o_endian_select // endian strap line
);
   int held = 0;
   logic keep;
   assign o_reset_pin_n = !i_hold_low;
   // cycles since pin release; straps only promise the hold time
   always @(posedge i_clk) begin
      if (i_hold_low) held <= 0;
      else if (held < STRAP_HOLD) held <= held + 1;
   end
   // past the hold time show the inverse so a late capture is caught
   assign keep = i_hold_low || (held < STRAP_HOLD);
   assign o_boot_select = keep ? i_boot : ~i_boot;
   assign o_endian_select = keep ? i_endian : ~i_endian;
endmodule

// ### verif/tb_reset_clock_phase_sequencer.sv
// self-checking bench for the reset and clock phase sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb_reset_clock_phase_sequencer;
   import rst_seq_pkg::*;
   typedef struct packed {
      logic wr;
      logic [3:0] a;
      logic [31:0] d;
      logic [3:0] be;
      logic [31:0] ex;
   } row_s;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hold_low = 1'b1;
   logic [1:0] boot = 2'h0;
   logic endian = 1'b0;
   logic ext_clk = 1'b0;
   avs_req_s avs = '0;
   logic pin_n, strap_e, endian_q, irst, gvalid, cpu_en, per_en, mif_en, mclk, mclk_oe;
   logic aa, aa_oe, aa_valid, ab, ab_oe, bus_oe, breq_valid, ser_oe, bypass, wait_q;
   logic [1:0] strap_b, boot_q;
   logic [31:0] rdata, q;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   // status word in run: phase 2, boot 2, endian 1, bypass per column
   row_s rows [14] = '{'{1'b0, 4'h4, 32'h0000_0000, 4'hf, 32'h0000_003a},
      '{1'b1, 4'h0, 32'h0000_0003, 4'hf, 32'h0000_0000},
      '{1'b0, 4'h0, 32'h0000_0000, 4'hf, 32'h0000_0003},
      '{1'b0, 4'h4, 32'h0000_0000, 4'hf, 32'h0000_001a},
      '{1'b1, 4'h0, 32'h0000_0000, 4'he, 32'h0000_0000},
      '{1'b0, 4'h0, 32'h0000_0000, 4'hf, 32'h0000_0003},
      '{1'b1, 4'h8, 32'hffff_ffff, 4'hf, 32'h0000_0000},
      '{1'b0, 4'h8, 32'h0000_0000, 4'hf, 32'h0000_0000},
      '{1'b1, 4'h4, 32'h0000_0000, 4'hf, 32'h0000_0000},
      '{1'b0, 4'h4, 32'h0000_0000, 4'hf, 32'h0000_001a},
      '{1'b1, 4'h0, 32'h0000_0001, 4'h1, 32'h0000_0000},
      '{1'b0, 4'h0, 32'h0000_0000, 4'hf, 32'h0000_0001},
      '{1'b0, 4'h4, 32'h0000_0000, 4'hf, 32'h0000_003a},
      '{1'b0, 4'hc, 32'h0000_0000, 4'hf, 32'h0000_0000}};

   always #10 i_clk = ~i_clk;

   board_reset_src src_u (.i_clk(i_clk), .i_hold_low(hold_low), .i_boot(boot),
      .i_endian(endian), .o_reset_pin_n(pin_n), .o_boot_select(strap_b),
      .o_endian_select(strap_e));

   reset_clock_phase_sequencer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reset_pin_n(pin_n),
      .i_input_clock_mode_bit(1'b1), .i_boot_select(strap_b), .i_endian_select(strap_e),
      .i_ext_mem_clock(ext_clk), .i_avs(avs), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_q), .o_internal_reset(irst), .o_groups_valid(gvalid),
      .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en), .o_mem_if_clk_en(mif_en),
      .o_mem_clock_out(mclk), .o_mem_clock_out_oe(mclk_oe), .o_aux_clock_out_a(aa),
      .o_aux_clock_out_a_oe(aa_oe), .o_aux_clock_out_a_valid(aa_valid),
      .o_aux_clock_out_b(ab), .o_aux_clock_out_b_oe(ab_oe), .o_mem_bus_oe(bus_oe),
      .o_bus_request_valid(breq_valid), .o_serial_timer_oe(ser_oe),
      .o_boot_select(boot_q), .o_endian_select(endian_q), .o_pll_bypass(bypass));

   task stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // the run needs about 1600 cycles; a hang stops well after that
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // one avalon word; request held until waitrequest is seen low at an edge
   task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] rd);
      @(posedge i_clk);
      avs <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: be};
      do @(posedge i_clk); while (wait_q !== 1'b0);
      rd = rdata;
      avs <= '0;
   endtask

   // pin low: groups parked, clock outputs held low, cpu enable slowed to one eighth
   task automatic pin_phase();
      int c;
      c = 0;
      @(posedge i_clk);
      hold_low <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      `CHK("bus oe", 1'b0, bus_oe)
      `CHK("bus_request_flag valid", 1'b0, breq_valid)
      `CHK("serial oe", 1'b0, ser_oe)
      `CHK("memclk", 2'b01, {mclk, mclk_oe})
      `CHK("aux a valid", 1'b0, aa_valid)
      `CHK("aux a", 2'b01, {aa, aa_oe})
      `CHK("aux b", 2'b01, {ab, ab_oe})
      repeat (64) begin
         @(posedge i_clk);
         #1;
         c += cpu_en;
      end
      `CHK("cpu en pin", 8, c)
   endtask

   // release the pin; count edges until internal reset drops
   task automatic release_pin(input logic [1:0] b, input logic e, input int abort_at);
      int n;
      int c;
      n = 0;
      c = 0;
      @(posedge i_clk);
      boot <= b;
      endian <= e;
      hold_low <= 1'b0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
         if (n >= 100 && n < 164) c += cpu_en;
         if (n == 6) `CHK("clock outs", 3'b111, {aa_valid, mclk_oe, ab_oe})
         if (n == 300) `CHK("valid early", 1'b0, gvalid)
      end while (irst !== 1'b0 && n < 600 && n != abort_at);
      if (abort_at == 0) begin
         `CHK("stretch", 515, n)
         `CHK("groups", 1'b1, gvalid)
         `CHK("cpu en stretch", 8, c)
         `CHK("straps", {b, e}, {boot_q, endian_q})
         `CHK("bypass", 1'b1, bypass)
      end
   endtask

   // run phase ratios over 64 input cycles
   task automatic run_checks();
      int c, p, m, b, k, r;
      logic pb, pk, pa;
      r = 0;
      pa = aa;
      c = 0;
      p = 0;
      m = 0;
      b = 0;
      k = 0;
      pb = ab;
      pk = mclk;
      repeat (64) begin
         @(posedge i_clk);
         #1;
         c += cpu_en;
         p += per_en;
         m += mif_en;
         b += (ab && !pb);
         k += (mclk && !pk);
         r += (aa && !pa);
         pa = aa;
         pb = ab;
         pk = mclk;
      end
      `CHK("cpu en", 64, c)
      `CHK("periph en", 32, p)
      `CHK("mem if en", 32, m)
      `CHK("memclk rises", 32, k)
      `CHK("aux b rises", 8, b)
      `CHK("aux a rises", 32, r)
      `CHK("groups on", 3'b111, {bus_oe, breq_valid, ser_oe})
   endtask

   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      pin_phase();
      release_pin(2'h2, 1'b1, 0);
      run_checks();
      for (int i = 0; i < 14; i++) begin
         av_xfer(rows[i].wr, rows[i].a, rows[i].d, rows[i].be, q);
         if (!rows[i].wr) `CHK("avalon read", rows[i].ex, q)
      end
      // source select 1 hands the pin to the external clock
      @(posedge i_clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      `CHK("ext memclk", 1'b1, mclk)
      av_xfer(1'b1, 4'h0, 32'h0000_0000, 4'hf, q);
      // pll request outside run is refused; a stretch is aborted midway
      pin_phase();
      av_xfer(1'b1, 4'h0, 32'h0000_0002, 4'hf, q);
      av_xfer(1'b0, 4'h0, 32'h0000_0000, 4'hf, q);
      `CHK("ctrl in reset", 32'h0000_0000, q)
      release_pin(2'h1, 1'b0, 200);
      @(posedge i_clk);
      hold_low <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      `CHK("aborted", 2'b10, {irst, gvalid})
      release_pin(2'h1, 1'b0, 0);
      run_checks();
      stop_test();
   end
endmodule
